// ---- common/crc_if.sv ----
`timescale 1ns/1ns
interface crc_if;
  logic clear;
  logic load;
  logic [7:0] data;
  logic [15:0] crc;
  modport engine (input clear, input load, input data, output crc);
  modport user (output clear, output load, output data, input crc);
endinterface

// ---- common/scan_pkg.sv ----
package scan_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_CONTROL = 6'h00;
  localparam logic [5:0] IDX_SETUP = 6'h01;
  localparam logic [5:0] IDX_STATUS = 6'h02;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_FAIL_INTERRUPT_ENABLE_BIT = 1;
  localparam int CTRL_RESET_BIT = 7;
  localparam int SETUP_SRC_LSB = 0;
  localparam int SETUP_MODE_LSB = 4;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_OK_BIT = 1;
  localparam logic OK_RESET = 1'b1;
  localparam logic [1:0] REGION_FLASH = 2'h0;
  localparam logic [1:0] REGION_BOOTAPP = 2'h1;
  localparam logic [1:0] REGION_BOOT = 2'h2;
  localparam logic [1:0] MODE_PRIORITY = 2'h0;
  localparam logic [1:0] MODE_STARTUP = 2'h1;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_RESIDUE = 16'h0000;
  localparam logic [7:0] NMI_VECTOR = 8'h00;
  // Last byte of the whole array; value of this build
  localparam logic [15:0] LAST_FLASH_LOCATION = 16'h0FFF;
  localparam logic [14:0] LAST_FLASH_WORD = LAST_FLASH_LOCATION[15:1];
  localparam int START_DELAY_CYC = 3;
  localparam logic [1:0] DELAY_LAST = 2'(START_DELAY_CYC - 1);
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_DELAY = 3'b001,
    ST_FETCH = 3'b011,
    ST_LOW = 3'b010,
    ST_HIGH = 3'b110,
    ST_CHECK = 3'b111
  } scan_state_t;
endpackage

// ---- rtl/crc16_engine.sv ----
`timescale 1ns/1ns
module crc16_engine import scan_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  crc_if.engine bus
);

  // One byte per clock, most significant bit first
  function automatic logic [15:0] crc_byte(logic [15:0] c, logic [7:0] d);
    logic fb;
    fb = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      fb = c[15] ^ d[i];
      c = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
    end
    return c;
  endfunction

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bus.crc <= CRC_INIT;
    else if (bus.clear)
      bus.crc <= CRC_INIT;
    else if (bus.load)
      bus.crc <= crc_byte(bus.crc, bus.data);
  end

endmodule

// ---- rtl/memory_checksum_scanner.sv ----
`timescale 1ns/1ns
module memory_checksum_scanner import scan_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dbg_access,
  input wire logic dbg_touch,
  input wire logic dbg_release_internal,
  input wire logic dbg_disconnect,
  input wire logic dbg_status_read,
  output logic [1:0] dbg_status_copy,
  input wire logic sleep_active,
  output logic flash_req,
  output logic [14:0] flash_addr,
  input wire logic [15:0] flash_rdata,
  output logic cpu_stall,
  output logic cpu_hold_reset,
  output logic nmi_req,
  output logic [7:0] nmi_vector,
  input wire logic reset_scan_enable_fuse,
  input wire logic [1:0] reset_scan_region_fuse,
  input wire logic [7:0] boot_section_end_fuse,
  input wire logic [7:0] code_section_end_fuse
);

  crc_if crc_bus();
  scan_state_t state;
  logic [18:0] pin_meta;
  logic [18:0] pin_sync;
  logic [1:0] boot_cnt;
  logic strap_done;
  logic in_boot;
  logic boot_fail;
  logic enable;
  logic fail_interrupt_enable;
  logic [1:0] mode;
  logic [1:0] scan_region_select;
  logic rst_pend;
  logic busy;
  logic ok;
  logic suspended;
  logic [1:0] dly;
  logic [14:0] word_addr;
  logic [14:0] last_word;
  logic [7:0] hi_byte;
  logic fuse_en;
  logic [1:0] fuse_region;
  logic [7:0] fuse_boot_end;
  logic [7:0] fuse_code_end;
  logic hit_ctrl;
  logic hit_setup;
  logic hit_stat;
  logic wr;
  logic wr_ctrl;
  logic wr_setup;
  logic wr_stat;
  logic start_sw;
  logic arm_dbg;
  logic stop_dbg;
  logic ok0_dbg;
  logic ok1_dbg;
  logic boot_start;
  logic done;
  logic pass;
  logic fail_evt;
  logic running;
  logic ok_rd;

  crc16_engine engine
  (
    .pclk(pclk),
    .presetn(presetn),
    .bus(crc_bus)
  );

  // Fuse levels are pins; two stages before anything reads them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
    end
    else
    begin
      pin_meta <= {reset_scan_enable_fuse, reset_scan_region_fuse,
                   boot_section_end_fuse, code_section_end_fuse};
      pin_sync <= pin_meta;
    end
  end

  assign {fuse_en, fuse_region, fuse_boot_end, fuse_code_end} = pin_sync;

  // APB decode; the debugger shares this port, marked by dbg_access
  assign hit_ctrl = (paddr == {IDX_CONTROL, 2'b00});
  assign hit_setup = (paddr == {IDX_SETUP, 2'b00});
  assign hit_stat = (paddr == {IDX_STATUS, 2'b00});
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~(hit_ctrl | hit_setup | hit_stat);
  assign wr = psel & penable & pwrite & pstrb[0] & ~nmi_req;
  assign wr_ctrl = wr & hit_ctrl;
  assign wr_setup = wr & hit_setup;
  assign wr_stat = wr & hit_stat & dbg_access;
  assign start_sw = wr_ctrl & pwdata[CTRL_ENABLE_BIT];
  assign arm_dbg = wr_stat & pwdata[STAT_BUSY_BIT];
  assign stop_dbg = wr_stat & ~pwdata[STAT_BUSY_BIT];
  assign ok0_dbg = wr_stat & ~pwdata[STAT_OK_BIT];
  assign ok1_dbg = wr_stat & pwdata[STAT_OK_BIT];
  assign boot_start = ~strap_done & (boot_cnt == STRAP_SETTLE) & fuse_en;
  // a suspended check never completes; it restarts on release
  assign done = (state == ST_CHECK) & ~suspended;
  // zero residue once the stored checksum is folded in
  assign pass = done & (crc_bus.crc == CRC_RESIDUE);
  // debugger pass write of 0 counts as a failure
  assign fail_evt = (done & ~pass) | ok0_dbg;
  assign running = busy & ~suspended & ~sleep_active;
  assign ok_rd = ok & ~busy;

  // checksum closes the region, so the last word ends the walk
  always_comb
  begin
    case (scan_region_select)
      REGION_BOOT: last_word = {fuse_boot_end, 7'h00} - 15'h0001;
      REGION_BOOTAPP: last_word = {fuse_code_end, 7'h00} - 15'h0001;
      default: last_word = LAST_FLASH_WORD;
    endcase
  end

  // Start-up check, taken once the synchronised fuses have settled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      boot_cnt <= 2'h0;
      strap_done <= 1'b0;
    end
    else if (!strap_done)
    begin
      if (boot_cnt == STRAP_SETTLE)
        strap_done <= 1'b1;
      else
        boot_cnt <= boot_cnt + 2'h1;
    end
  end

  // failed start-up check keeps the CPU in reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      in_boot <= 1'b0;
      boot_fail <= 1'b0;
    end
    else if (boot_start)
      in_boot <= 1'b1;
    else if (in_boot && done)
    begin
      in_boot <= 1'b0;
      boot_fail <= ~pass;
    end
  end

  assign cpu_hold_reset = ~strap_done | in_boot | boot_fail;

  // start-up leaves enable set, mode non-zero and region shown
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      enable <= 1'b0;
    else if (rst_pend)
      enable <= 1'b0;
    else if (boot_start)
      enable <= 1'b1;
    else if (wr_ctrl)
      enable <= pwdata[CTRL_ENABLE_BIT];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode <= MODE_PRIORITY;
      scan_region_select <= REGION_FLASH;
    end
    else if (rst_pend)
    begin
      mode <= MODE_PRIORITY;
      scan_region_select <= REGION_FLASH;
    end
    else if (boot_start)
    begin
      mode <= MODE_STARTUP;
      scan_region_select <= fuse_region;
    end
    else if (wr_setup && !busy)
    begin
      mode <= pwdata[SETUP_MODE_LSB +: 2];
      scan_region_select <= pwdata[SETUP_SRC_LSB +: 2];
    end
  end

  // set-only enable, untouched by the reset strobe
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fail_interrupt_enable <= 1'b0;
    else if (wr_ctrl && pwdata[CTRL_FAIL_INTERRUPT_ENABLE_BIT] && !busy)
      fail_interrupt_enable <= 1'b1;
  end

  // Reset strobe acts one cycle after the write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rst_pend <= 1'b0;
    else
      rst_pend <= wr_ctrl & pwdata[CTRL_RESET_BIT] &
                  (~fail_interrupt_enable | ~busy);
  end

  // busy drops on the same edge that sets pass
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      busy <= 1'b0;
    else if (rst_pend || stop_dbg)
      busy <= 1'b0;
    else if (start_sw || arm_dbg || boot_start)
      busy <= 1'b1;
    else if (done)
      busy <= 1'b0;
  end

  // debugger may force pass to 1
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ok <= OK_RESET;
    else if (rst_pend || fail_evt)
      ok <= 1'b0;
    else if (start_sw || arm_dbg || boot_start)
      ok <= 1'b0;
    else if (pass || ok1_dbg)
      ok <= 1'b1;
  end

  // raw request, never gated by a global enable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      nmi_req <= 1'b0;
    else if (fail_evt && fail_interrupt_enable)
      nmi_req <= 1'b1;
  end

  assign nmi_vector = NMI_VECTOR;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      suspended <= 1'b0;
    else if (dbg_touch)
      suspended <= 1'b1;
    else if (dbg_release_internal || dbg_disconnect || dbg_status_read)
      suspended <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dbg_status_copy <= {OK_RESET, 1'b0};
    else
      dbg_status_copy <= {ok_rd, busy};
  end

  // Scan sequencer; a word takes FETCH, LOW and HIGH
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= ST_IDLE;
      dly <= 2'h0;
    end
    else if (rst_pend || stop_dbg)
      state <= ST_IDLE;
    else if (start_sw)
    begin
      state <= ST_DELAY;
      dly <= 2'h0;
    end
    // restart from the start after suspension
    else if (arm_dbg || boot_start || (suspended && busy))
    begin
      state <= ST_DELAY;
      dly <= DELAY_LAST;
    end
    else
    begin
      case (state)
        ST_IDLE: state <= ST_IDLE;
        ST_DELAY:
          if (running)
          begin
            if (dly == DELAY_LAST)
              state <= ST_FETCH;
            else
              dly <= dly + 2'h1;
          end
        ST_FETCH:
          if (running)
            state <= ST_LOW;
        ST_LOW: state <= ST_HIGH;
        ST_HIGH: state <= (word_addr == last_word) ? ST_CHECK : ST_FETCH;
        ST_CHECK: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      word_addr <= 15'h0000;
    else if (state == ST_DELAY)
      word_addr <= 15'h0000;
    else if (state == ST_HIGH)
      word_addr <= word_addr + 15'h0001;
  end

  // Flash answers one cycle after the request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hi_byte <= 8'h00;
    else if (state == ST_LOW)
      hi_byte <= flash_rdata[15:8];
  end

  assign flash_req = (state == ST_FETCH) & running;
  assign flash_addr = word_addr;
  // CPU stalled for the whole scan, not during the launch delay
  assign cpu_stall = busy & (state != ST_IDLE) & (state != ST_DELAY);

  assign crc_bus.clear = (state == ST_DELAY);
  // low byte of each word first, it holds the lower address
  assign crc_bus.load = (state == ST_LOW) | (state == ST_HIGH);
  assign crc_bus.data = (state == ST_LOW) ? flash_rdata[7:0] : hi_byte;

  // Read data registered in the setup phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable)
    begin
      prdata <= 32'h0000_0000;
      if (hit_ctrl)
      begin
        prdata[CTRL_ENABLE_BIT] <= enable;
        prdata[CTRL_FAIL_INTERRUPT_ENABLE_BIT] <= fail_interrupt_enable;
      end
      else if (hit_setup)
      begin
        prdata[SETUP_MODE_LSB +: 2] <= mode;
        prdata[SETUP_SRC_LSB +: 2] <= scan_region_select;
      end
      else if (hit_stat)
      begin
        prdata[STAT_BUSY_BIT] <= busy;
        prdata[STAT_OK_BIT] <= ok_rd;
      end
    end
  end

  a_launch_delay: assert property (@(posedge pclk) disable iff (!presetn)
    start_sw ##1 (running && !wr && !dbg_touch)[*3] |=> state == ST_FETCH)
    else $error("scan did not start three cycles after enable");
  a_fetch_rate: assert property (@(posedge pclk) disable iff (!presetn)
    flash_req |=> !flash_req ##1 !flash_req)
    else $error("flash fetched faster than every third cycle");
  a_setup_lock: assert property (@(posedge pclk) disable iff (!presetn)
    busy && wr_setup && !boot_start |=> $stable(scan_region_select))
    else $error("setup changed while busy");
  a_nmi_cause: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(nmi_req) |-> $past(fail_evt && fail_interrupt_enable))
    else $error("interrupt raised without failure");
  a_nmi_hold: assert property (@(posedge pclk) disable iff (!presetn)
    nmi_req && psel && penable && pwrite |=> $stable(enable) && $stable(ok))
    else $error("write accepted after interrupt");
  a_pass_update: assert property (@(posedge pclk) disable iff (!presetn)
    pass && !stop_dbg && !rst_pend && !wr |=> ok && !busy && ok_rd)
    else $error("pass did not set flag and clear busy");
  a_fail_nmi: assert property (@(posedge pclk) disable iff (!presetn)
    fail_evt && fail_interrupt_enable |=> nmi_req && !ok)
    else $error("failure did not raise interrupt");
  a_suspend_busy: assert property (@(posedge pclk) disable iff (!presetn)
    suspended && busy && !wr && !rst_pend |=> busy && !flash_req)
    else $error("suspended scan lost busy or fetched");
  a_sleep_halt: assert property (@(posedge pclk) disable iff (!presetn)
    sleep_active |-> !flash_req)
    else $error("fetch during sleep");
  a_boot_hold: assert property (@(posedge pclk) disable iff (!presetn)
    in_boot && done && !pass |=> cpu_hold_reset [*4])
    else $error("failed start-up check released the CPU");
  a_crc_seed: assert property (@(posedge pclk) disable iff (!presetn)
    state == ST_DELAY |=> crc_bus.crc == CRC_INIT)
    else $error("checksum not seeded at launch");

endmodule

// ---- sim/flash_model.sv ----
`timescale 1ns/1ns
module flash_model
(
  input wire logic pclk,
  input wire logic flash_req,
  input wire logic [14:0] flash_addr,
  output logic [15:0] flash_rdata
);
  logic [15:0] mem [0:2047];
  initial flash_rdata = 16'h0000;
  // Data valid one cycle only; toggles so stale reads show up
  always @(posedge pclk)
  begin
    if (flash_req)
      flash_rdata <= mem[flash_addr[10:0]];
    else
      flash_rdata <= ~flash_rdata;
  end
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0] b);
    for (int k = 7; k >= 0; k--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ b[k]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction
  // checksum high byte first in last word
  task automatic seal(input int last);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int i = 0; i < 2048; i++)
    begin
      mem[i] = {8'(i * 7 + 3), 8'(i)};
      if (i < last)
        c = crc_step(crc_step(c, mem[i][7:0]), mem[i][15:8]);
    end
    mem[last] = {c[7:0], c[15:8]};
  endtask
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
  begin \
    total_checks++; \
    if ((got) !== (ex)) \
    begin \
      $display("[FAIL] %s exp %0h got %0h", nm, ex, got); \
      miscompares++; \
    end \
  end
module testbench import scan_pkg::*;
;
  typedef struct packed
  {
    logic [1:0] region;
    logic [10:0] last;
    logic bad;
    logic [7:0] status;
  } row_t;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, dbg_access = 1'b0, sleep_active = 1'b0;
  logic en_fuse = 1'b0;
  logic [1:0] reg_fuse = 2'h0;
  logic [3:0] dbg_pulse = 4'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, flash_req, cpu_stall, cpu_hold_reset, nmi_req;
  logic err;
  logic [1:0] dbg_status_copy;
  logic [14:0] flash_addr;
  logic [15:0] flash_rdata;
  logic [7:0] nmi_vector;
  int miscompares = 0, total_checks = 0, n;
  row_t rows [4] = '{'{REGION_BOOT, 11'h07F, 1'b0, 8'h02},
    '{REGION_BOOTAPP, 11'h0FF, 1'b0, 8'h02},
    '{REGION_FLASH, 11'h7FF, 1'b0, 8'h02},
    '{REGION_BOOT, 11'h07F, 1'b1, 8'h00}};

  always #5 pclk = ~pclk;

  memory_checksum_scanner DUT
  (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'h1), .prdata, .pready, .pslverr, .dbg_access,
    .dbg_touch(dbg_pulse[0]), .dbg_release_internal(dbg_pulse[1]),
    .dbg_disconnect(dbg_pulse[2]), .dbg_status_read(dbg_pulse[3]),
    .dbg_status_copy, .sleep_active, .flash_req, .flash_addr,
    .flash_rdata, .cpu_stall, .cpu_hold_reset, .nmi_req, .nmi_vector,
    .reset_scan_enable_fuse(en_fuse), .reset_scan_region_fuse(reg_fuse),
    .boot_section_end_fuse(8'h01), .code_section_end_fuse(8'h02)
  );
  flash_model fm
  (
    .pclk, .flash_req, .flash_addr, .flash_rdata
  );

  task automatic complete_run();
    if (miscompares == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [7:0] d, input logic dbg);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    dbg_access <= dbg;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    if (k >= 20)
    begin
      miscompares++;
      complete_run();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    dbg_access <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] ex,
                      input string nm);
    apb(1'b0, a, 8'h00, 1'b0);
    `CHK(nm, ex, rd[7:0])
  endtask

  // Polling is bounded; a stuck busy flag ends the run
  task automatic wait_idle();
    int k;
    k = 0;
    do
    begin
      apb(1'b0, 8'h08, 8'h00, 1'b0);
      k++;
    end
    while (rd[0] !== 1'b0 && k < 4000);
    if (k >= 4000)
    begin
      miscompares++;
      complete_run();
    end
  endtask

  task automatic count_req(input int cyc, output int c);
    c = 0;
    repeat (cyc)
    begin
      @(negedge pclk);
      if (flash_req === 1'b1)
        c++;
    end
  endtask

  task automatic until_req(output int c);
    c = 0;
    do
    begin
      @(negedge pclk);
      c++;
    end
    while (flash_req !== 1'b1 && c < 100);
    if (c >= 100)
    begin
      miscompares++;
      complete_run();
    end
  endtask

  task automatic pulse(input logic [3:0] p);
    @(posedge pclk);
    dbg_pulse <= p;
    @(posedge pclk);
    dbg_pulse <= 4'h0;
  endtask

  // region first, mode left at zero, then enable
  task automatic start(input logic [1:0] region);
    apb(1'b1, 8'h04, {6'h00, region}, 1'b0);
    apb(1'b1, 8'h00, 8'h01, 1'b0);
  endtask

  task automatic do_reset(input logic bad);
    @(posedge pclk);
    presetn <= 1'b0;
    en_fuse <= 1'b1;
    reg_fuse <= REGION_BOOT;
    fm.seal(127);
    if (bad)
      fm.mem[5] = ~fm.mem[5];
    repeat (12) @(posedge pclk);
    `CHK("nmi cleared", 1'b0, nmi_req)
    presetn <= 1'b1;
  endtask

  initial
  begin
    #900000;
    miscompares++;
    complete_run();
  end

  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rchk(8'h00, 8'h00, "control rst");
    rchk(8'h04, 8'h00, "setup rst");
    rchk(8'h08, 8'h02, "status rst");
    apb(1'b0, 8'h0C, 8'h00, 1'b0);
    `CHK("unmapped", 1'b1, err)
    foreach (rows[i])
    begin
      fm.seal(rows[i].last);
      if (rows[i].bad)
        fm.mem[5] = ~fm.mem[5];
      start(rows[i].region);
      rchk(8'h08, 8'h01, "status busy");
      wait_idle();
      rchk(8'h08, rows[i].status, "status end");
    end
    apb(1'b1, 8'h08, 8'h02, 1'b1);
    rchk(8'h08, 8'h02, "dbg pass set");
    apb(1'b1, 8'h08, 8'h00, 1'b0);
    rchk(8'h08, 8'h02, "cpu status wr");
    fm.seal(127);
    start(REGION_BOOT);
    until_req(n);
    `CHK("launch delay", 4, n)
    until_req(n);
    `CHK("fetch period", 3, n)
    `CHK("cpu stall", 1'b1, cpu_stall)
    apb(1'b1, 8'h04, 8'h01, 1'b0);
    apb(1'b1, 8'h00, 8'h02, 1'b0);
    wait_idle();
    rchk(8'h04, 8'h02, "setup locked");
    rchk(8'h00, 8'h00, "fail_interrupt_enable locked");
    apb(1'b1, 8'h00, 8'h01, 1'b0);
    sleep_active <= 1'b1;
    count_req(20, n);
    `CHK("sleep fetches", 0, n)
    @(posedge pclk);
    sleep_active <= 1'b0;
    wait_idle();
    rchk(8'h08, 8'h02, "after wake");
    apb(1'b1, 8'h00, 8'h01, 1'b0);
    repeat (30) @(posedge pclk);
    pulse(4'h1);
    count_req(20, n);
    `CHK("suspend fetches", 0, n)
    rchk(8'h08, 8'h01, "suspended busy");
    `CHK("dbg copy", 2'b01, dbg_status_copy)
    pulse(4'h8);
    until_req(n);
    `CHK("restart addr", 15'h0000, flash_addr)
    wait_idle();
    rchk(8'h08, 8'h02, "restart pass");
    apb(1'b1, 8'h00, 8'h01, 1'b0);
    repeat (30) @(posedge pclk);
    pulse(4'h1);
    apb(1'b1, 8'h08, 8'h02, 1'b1);
    pulse(4'h4);
    count_req(20, n);
    `CHK("abort fetches", 0, n)
    apb(1'b0, 8'h08, 8'h00, 1'b0);
    `CHK("abort busy", 1'b0, rd[0])
    pulse(4'h1);
    apb(1'b1, 8'h08, 8'h03, 1'b1);
    count_req(10, n);
    `CHK("armed fetches", 0, n)
    pulse(4'h2);
    wait_idle();
    rchk(8'h08, 8'h02, "armed pass");
    apb(1'b1, 8'h00, 8'h01, 1'b0);
    apb(1'b1, 8'h00, 8'h80, 1'b0);
    rchk(8'h08, 8'h00, "strobe status");
    rchk(8'h04, 8'h00, "strobe setup");
    apb(1'b1, 8'h04, {6'h00, REGION_BOOT}, 1'b0);
    apb(1'b1, 8'h00, 8'h02, 1'b0);
    rchk(8'h00, 8'h02, "fail_interrupt_enable set");
    apb(1'b1, 8'h00, 8'h00, 1'b0);
    rchk(8'h00, 8'h02, "fail_interrupt_enable sticky");
    fm.mem[5] = ~fm.mem[5];
    apb(1'b1, 8'h00, 8'h03, 1'b0);
    wait_idle();
    rchk(8'h08, 8'h00, "fail status");
    `CHK("nmi raised", 1'b1, nmi_req)
    `CHK("nmi vector", 8'h00, nmi_vector)
    apb(1'b1, 8'h00, 8'h00, 1'b0);
    rchk(8'h00, 8'h03, "control frozen");
    apb(1'b1, 8'h04, 8'h01, 1'b0);
    rchk(8'h04, 8'h02, "setup frozen");
    do_reset(1'b0);
    n = 0;
    while (cpu_hold_reset !== 1'b0 && n < 3000)
    begin
      @(negedge pclk);
      n++;
    end
    `CHK("boot released", 1'b0, cpu_hold_reset)
    rchk(8'h00, 8'h01, "boot control");
    rchk(8'h04, {2'b00, MODE_STARTUP, 2'b00, REGION_BOOT},
         "boot setup");
    apb(1'b1, 8'h00, 8'h02, 1'b0);
    apb(1'b1, 8'h08, 8'h00, 1'b1);
    rchk(8'h08, 8'h00, "dbg fail status");
    `CHK("dbg fail nmi", 1'b1, nmi_req)
    do_reset(1'b1);
    repeat (1500) @(posedge pclk);
    `CHK("boot held", 1'b1, cpu_hold_reset)
    complete_run();
  end
endmodule
